// ### rcf_regs.v
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.vh"
module rcf_regs (
  input wire aclk, // Clock, 50 MHz
  input wire aresetn, // Sync reset, active low
  input wire ce, // Clock enable, freezes state when low
  input wire [8:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [8:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire center_converter, // Strap pin: center side
  input wire frame_start, // Pulse: maintenance frame begins
  input wire frame_done, // Pulse: frame fully sent
  input wire [23:0] model_info, // Own model-info bytes 0x55..0x57
  output reg [23:0] model_info_bits, // Frame bits 24..47
  output reg frame_busy // Frame fields held
);
  // ==========================================
  // Synchronised inputs
  // Strap is seen two cycles after reset; earlier writes are dropped
  reg cc_s1, cc_s2, fs_s1, fs_s2, fd_s1, fd_s2, fs_d;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cc_s1 <= 1'b0;
      cc_s2 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fd_s1 <= 1'b0;
      fd_s2 <= 1'b0;
      fs_d <= 1'b0;
    end else if (ce) begin
      cc_s1 <= center_converter;
      cc_s2 <= cc_s1;
      fs_s1 <= frame_start;
      fs_s2 <= fs_s1;
      fd_s1 <= frame_done;
      fd_s2 <= fd_s1;
      fs_d <= fs_s2;
    end
  end
  wire start_evt = fs_s2 & ~fs_d & ~frame_busy;

  // ==========================================
  // Registers
  reg [1:0] reserved_bits;
  reg [1:0] op_code;
  reg [1:0] layout_sel;
  reg [7:0] target_address_byte;
  reg [7:0] command_data_byte;
  wire [1:0] vendor_cap = `RCF_VCAP_RESET;
  wire [7:0] ctrl_rd = {reserved_bits, vendor_cap, op_code, layout_sel};

  // Anything else answers with an error and reads zero
  function is_mapped;
    input [8:0] a;
    begin
      if (a == `RCF_ADDR_CONTROL) begin
        is_mapped = 1'b1;
      end else if (a == `RCF_ADDR_ADDRESS) begin
        is_mapped = 1'b1;
      end else if (a == `RCF_ADDR_DATA) begin
        is_mapped = 1'b1;
      end else if (a == `RCF_ADDR_STATUS) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  // ==========================================
  // Write channel: address and data taken in either order
  reg aw_held, w_held;
  reg [8:0] aw_q;
  reg [7:0] w_q;
  reg w_en;
  wire [8:0] wa = aw_held ? aw_q : s_axi_awaddr;
  // Only byte lane 0 carries a register; upper lanes are ignored
  wire [7:0] wd = w_held ? w_q : s_axi_wdata[7:0];
  wire we_lane = w_held ? w_en : s_axi_wstrb[0];
  wire aw_ok = aw_held | (s_axi_awvalid & s_axi_awready);
  wire w_ok = w_held | (s_axi_wvalid & s_axi_wready);
  wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
  // Only the center-side converter may change the command fields
  wire wr_en = do_wr & we_lane & cc_s2;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCF_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 9'h000;
      w_q <= 8'h00;
      w_en <= 1'b0;
      reserved_bits <= 2'h0;
      op_code <= 2'h0;
      layout_sel <= `RCF_LAYOUT_EXTENDED;
      target_address_byte <= `RCF_BYTE_RESET;
      command_data_byte <= `RCF_BYTE_RESET;
    end else if (ce) begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wa) ? `RCF_RESP_OKAY : `RCF_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_q <= s_axi_awaddr;
          s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_q <= s_axi_wdata[7:0];
          w_en <= s_axi_wstrb[0];
          s_axi_wready <= 1'b0;
        end
      end
      if (wr_en) begin
        if (wa == `RCF_ADDR_CONTROL) begin
          // Reserved top bits stored as written; software keeps them zero
          reserved_bits <= wd[`RCF_RSV_LSB +: 2];
          op_code <= wd[`RCF_OPCODE_LSB +: 2];
          layout_sel <= wd[`RCF_LAYOUT_LSB +: 2];
        end else if (wa == `RCF_ADDR_ADDRESS) begin
          target_address_byte <= wd;
        end else if (wa == `RCF_ADDR_DATA) begin
          command_data_byte <= wd;
        end
      end
    end
  end

  // ==========================================
  // Read channel, answer one cycle after address taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RCF_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `RCF_RESP_OKAY : `RCF_RESP_SLVERR;
        if (s_axi_araddr == `RCF_ADDR_CONTROL) begin
          s_axi_rdata <= {24'h00_0000, ctrl_rd};
        end else if (s_axi_araddr == `RCF_ADDR_ADDRESS) begin
          s_axi_rdata <= {24'h00_0000, target_address_byte};
        end else if (s_axi_araddr == `RCF_ADDR_DATA) begin
          s_axi_rdata <= {24'h00_0000, command_data_byte};
        end else if (s_axi_araddr == `RCF_ADDR_STATUS) begin
          // Status word: bit 0 fields held, bit 1 strap seen as center side
          s_axi_rdata <= {30'h0000_0000, cc_s2, frame_busy};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================
  // Frame field selection
  // Extended layout only on the center side; reserved codes fall back to normal
  wire ext = cc_s2 && (layout_sel == `RCF_LAYOUT_EXTENDED);
  wire [23:0] fields = ext ?
    {command_data_byte, target_address_byte, ctrl_rd} : model_info;
  wire [23:0] held;

  rcf_snap u_snap (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .load(start_evt),
    .din(fields),
    .dout(held)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      frame_busy <= 1'b0;
      model_info_bits <= 24'h00_0000;
    end else if (ce) begin
      if (start_evt) begin
        frame_busy <= 1'b1;
      end else if (fd_s2) begin
        frame_busy <= 1'b0;
      end
      // Normal layout passes own info live while idle; held during a frame
      model_info_bits <= frame_busy ? held : fields;
    end
  end
endmodule
`default_nettype wire

// ### rcf_map.vh
// Notes on behaviour
// - Registers used only by center-side converter
// - Low bits select normal or extended layout
// - Normal layout sends own model-info bytes
// - Extended layout sends remote-command register bytes
// - Bits 3:2 carry the operation code
// - Bits 5:4 read-only capability, reset 10
// - Address register fills frame bits 39:32
// - Data register fills frame bits 47:40
`ifndef RCF_MAP_VH
`define RCF_MAP_VH
// ==========================================
// Register indices
`define RCF_IDX_CONTROL 8'h4a
`define RCF_IDX_ADDRESS 8'h4b
`define RCF_IDX_DATA 8'h4c
`define RCF_IDX_MODEL0 8'h55
`define RCF_IDX_MODEL1 8'h56
`define RCF_IDX_MODEL2 8'h57
`define RCF_IDX_STATUS 8'h60
// ==========================================
// Bus byte addresses: index times four, status word at its own address
`define RCF_ADDR_CONTROL 9'h128
`define RCF_ADDR_ADDRESS 9'h12c
`define RCF_ADDR_DATA 9'h130
`define RCF_ADDR_STATUS 9'h060
// ==========================================
// Control register fields
`define RCF_LAYOUT_LSB 0
`define RCF_OPCODE_LSB 2
`define RCF_VCAP_LSB 4
`define RCF_RSV_LSB 6
`define RCF_LAYOUT_NORMAL 2'h0
`define RCF_LAYOUT_EXTENDED 2'h2
`define RCF_VCAP_RESET 2'h2
`define RCF_CTRL_RESET 8'h22
`define RCF_BYTE_RESET 8'h00
`define RCF_RESP_OKAY 2'h0
`define RCF_RESP_SLVERR 2'h2
`endif

// ### rcf_snap.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Frame field snapshot, read data registered
module rcf_snap (
  input wire aclk, // Clock
  input wire aresetn, // Sync reset, active low
  input wire ce, // Clock enable
  input wire load, // Capture at frame start
  input wire [23:0] din, // Fields to capture
  output reg [23:0] dout // Held fields
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 24'h00_0000;
    end else if (ce && load) begin
      dout <= din;
    end
  end
endmodule
`default_nettype wire

// ### rcf_framer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Frame transmitter model
module rcf_framer (
  input wire logic aclk, // Clock
  input wire logic frame_busy, // Fields held
  input wire logic [23:0] model_info_bits, // Frame bits 24..47
  output logic frame_start, // Frame begins
  output logic frame_done // Frame sent
);
  initial begin
    frame_start = 1'b0;
    frame_done = 1'b0;
  end
  // Sample one edge after the hold shows, once the snapshot reached the output
  task automatic open_frame(output logic good, output logic [23:0] seen);
    int n;
    frame_start <= 1'b1;
    for (n = 0; n < 20 && frame_busy !== 1'b1; n++) @(posedge aclk);
    @(posedge aclk);
    good = frame_busy;
    seen = model_info_bits;
  endtask
  task automatic close_frame(output logic good);
    int n;
    frame_start <= 1'b0;
    frame_done <= 1'b1;
    for (n = 0; n < 20 && frame_busy !== 1'b0; n++) @(posedge aclk);
    good = !frame_busy;
    frame_done <= 1'b0;
    // Done crosses a two-flop synchroniser before the next start may count
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ### rcf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus and frame checks
module rcf_assertions (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic s_axi_awvalid, // Bus
  input wire logic s_axi_awready, // Bus
  input wire logic s_axi_wvalid, // Bus
  input wire logic s_axi_wready, // Bus
  input wire logic s_axi_bvalid, // Bus
  input wire logic [8:0] s_axi_araddr, // Bus
  input wire logic s_axi_arvalid, // Bus
  input wire logic s_axi_arready, // Bus
  input wire logic s_axi_rvalid, // Bus
  input wire logic [31:0] s_axi_rdata, // Bus
  input wire logic [1:0] s_axi_rresp, // Bus
  input wire logic frame_start, // Frame
  input wire logic frame_busy, // Frame
  input wire logic [23:0] model_info_bits // Frame
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [8:0] ra;
  always @(posedge aclk) if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_vcap_fixed: assert property (s_axi_rvalid && ra == 9'h128 |->
    s_axi_rdata[31:4] == 28'h000_0002 && s_axi_rresp == 2'h0) else $error("capability bits");
  a_unmapped_err: assert property (s_axi_rvalid && !(ra inside {9'h128, 9'h12c, 9'h130, 9'h060})
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  a_frame_taken: assert property ($rose(frame_start) && !frame_busy |-> ##[1:4] frame_busy)
    else $error("frame start missed");
  a_fields_held: assert property (frame_busy && $past(frame_busy, 2) |->
    $stable(model_info_bits)) else $error("frame fields moved");
endmodule
`default_nettype wire

// ### tb_remote_command_frame_fields.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register bus and frame field bench
module tb_remote_command_frame_fields;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic center_converter, frame_start, frame_done, frame_busy, ok;
  logic [8:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] model_info, model_info_bits, bits;
  int err_total, comparisons, seed, i;
  rcf_regs uut (.*);
  rcf_framer framer (.*);
  function automatic logic [1:0] resp_of(input logic [8:0] a);
    return (a inside {9'h128, 9'h12c, 9'h130, 9'h060}) ? 2'h0 : 2'h2;
  endfunction
  function automatic logic [23:0] exp_bits(input logic [7:0] c, a, d, input logic [23:0] m);
    return (c[1:0] == 2'h2) ? {d, a, c} : m;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic edge_until(ref logic s);
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s === 1'b1) return;
    end
    err_total++;
    final_report();
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    edge_until(s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    edge_until(s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({30'h0000_0000, s_axi_bresp}, {30'h0000_0000, resp_of(a)});
    // Let an edge pass so a following call does not reassign bready at once
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [8:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    edge_until(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    edge_until(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, e);
    check({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, resp_of(a)});
    @(posedge aclk);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, model_info} = '0;
    {ce, center_converter} = 2'h3;
    seed = 32'h3777;
    do_reset();
    rd_reg(9'h128, 32'h0000_0022);
    rd_reg(9'h134, 32'h0000_0000);
    wr_reg(9'h134, 8'h5a, 4'h1);
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      q = $random(seed);
      model_info <= q[23:0];
      wr_reg(9'h128, {2'h0, r[17:16], i[3:0]}, 4'h1);
      wr_reg(9'h12c, r[7:0], 4'h1);
      wr_reg(9'h130, r[15:8], 4'h1);
      rd_reg(9'h128, {24'h00_0000, 4'h2, i[3:0]});
      framer.open_frame(ok, bits);
      check({31'h0000_0000, ok}, 32'h0000_0001);
      check({8'h00, bits}, {8'h00, exp_bits({4'h2, i[3:0]}, r[7:0], r[15:8], q[23:0])});
      wr_reg(9'h12c, ~r[7:0], 4'h1);
      @(posedge aclk);
      check({8'h00, model_info_bits}, {8'h00, bits});
      framer.close_frame(ok);
      check({31'h0000_0000, ok}, 32'h0000_0001);
    end
    center_converter <= 1'b0;
    repeat (3) @(posedge aclk);
    wr_reg(9'h130, ~r[15:8], 4'h1);
    rd_reg(9'h130, {24'h00_0000, r[15:8]});
    rd_reg(9'h060, 32'h0000_0000);
    center_converter <= 1'b1;
    repeat (3) @(posedge aclk);
    wr_reg(9'h130, ~r[15:8], 4'h0);
    rd_reg(9'h130, {24'h00_0000, r[15:8]});
    do_reset();
    rd_reg(9'h12c, 32'h0000_0000);
    rd_reg(9'h128, 32'h0000_0022);
    final_report();
  end
endmodule
bind rcf_regs rcf_assertions chk (.*);
`default_nettype wire
